/* design/revflg_pkg.sv */
// package for the event flag unit: register map, field layout, bus types
// assumes a 32-bit axi4-lite register bus and single-cycle event pulses
package revflg_pkg;

	// ------------------------------------------------------------------
	// register map
	// ------------------------------------------------------------------
	localparam logic [7:0] REVFLG_OFS_ENABLE = 8'h30;
	localparam logic [7:0] REVFLG_OFS_FLAGS  = 8'h34;
	localparam logic [7:0] REVFLG_OFS_CLEAR  = 8'h38;

	// ------------------------------------------------------------------
	// field layout
	// ------------------------------------------------------------------
	localparam int REVFLG_NUM_SRC    = 7;
	localparam int REVFLG_BIT_FIRST  = 0;
	localparam int REVFLG_BIT_SECOND = 1;
	localparam int REVFLG_BIT_WAKEUP = 2;
	localparam int REVFLG_BIT_CAPT   = 3;
	localparam int REVFLG_BIT_OVRUN  = 4;
	localparam int REVFLG_BIT_PERIOD = 6;

	// bit 5 is reserved in all three registers
	localparam logic [6:0] REVFLG_IMPL_MASK = 7'h5F;

	// ------------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------------
	localparam logic [6:0]  REVFLG_RST_ENABLE = 7'h00;
	localparam logic [6:0]  REVFLG_RST_FLAGS  = 7'h00;
	localparam logic [31:0] REVFLG_RST_CLEAR  = 32'h0000007F;

	// ------------------------------------------------------------------
	// bus constants and types
	// ------------------------------------------------------------------
	localparam logic [1:0]  REVFLG_RESP_OKAY   = 2'h0;
	localparam logic [1:0]  REVFLG_RESP_SLVERR = 2'h2;
	localparam logic [31:0] REVFLG_ZERO_WORD   = 32'h00000000;

	typedef struct packed {
		logic first_match_event;
		logic second_match_event;
		logic wakeup_countdown_event;
		logic capture_event;
		logic capture_overrun_event;
		logic periodic_tick_event;
	} revflg_events_t;

	typedef struct packed {
		logic [31:0] data;
		logic [1:0]  resp;
	} revflg_rdata_t;

endpackage : revflg_pkg

/* design/revflg_unit.sv */
// event flag unit: interrupt enables, sticky event flags, flag clear
// assumes timers outside raise one-cycle event pulses on aclk
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module revflg_unit (
	input  wire logic                   aclk,
	input  wire logic                   aresetn,
	input  wire revflg_pkg::revflg_events_t events,
	input  wire logic [7:0]             s_axi_awaddr,
	input  wire logic [2:0]             s_axi_awprot,
	input  wire logic                   s_axi_awvalid,
	output var  logic                   s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output var  logic                   s_axi_wready,
	output var  logic [1:0]             s_axi_bresp,
	output var  logic                   s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	input  wire logic [7:0]             s_axi_araddr,
	input  wire logic [2:0]             s_axi_arprot,
	input  wire logic                   s_axi_arvalid,
	output var  logic                   s_axi_arready,
	output var  logic [31:0]            s_axi_rdata,
	output var  logic [1:0]             s_axi_rresp,
	output var  logic                   s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	output var  logic                   irq
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [6:0]  enable;
	logic [6:0]  flags;
	logic [6:0]  event_vec;
	logic [6:0]  clear_vec;
	logic [6:0]  next_flags;
	logic [6:0]  next_enable;
	logic [7:0]  aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;
	logic        do_write;
	logic        wr_enable;
	logic        wr_clear;
	logic        lane0;
	logic        rd_take;
	revflg_pkg::revflg_rdata_t rd_word;

	// ------------------------------------------------------------------
	// event vector in register bit order
	// ------------------------------------------------------------------
	always_comb begin
		event_vec = 7'h00;
		event_vec[revflg_pkg::REVFLG_BIT_FIRST]  =
			events.first_match_event;
		event_vec[revflg_pkg::REVFLG_BIT_SECOND] =
			events.second_match_event;
		event_vec[revflg_pkg::REVFLG_BIT_WAKEUP] =
			events.wakeup_countdown_event;
		event_vec[revflg_pkg::REVFLG_BIT_CAPT]   =
			events.capture_event;
		event_vec[revflg_pkg::REVFLG_BIT_OVRUN]  =
			events.capture_overrun_event;
		event_vec[revflg_pkg::REVFLG_BIT_PERIOD] =
			events.periodic_tick_event;
	end

	// ------------------------------------------------------------------
	// write channel capture: address and data in either order
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			aw_addr <= 8'h00;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held <= 1'b1;
			aw_addr <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held <= 1'b0;
			w_data <= revflg_pkg::REVFLG_ZERO_WORD;
			w_strb <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held <= 1'b1;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (do_write) begin
			w_held <= 1'b0;
		end
	end

	// ready is low while a word is held, so each channel takes one item
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
		end else begin
			s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
			s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid;
		end
	end

	assign do_write  = aw_held && w_held && !s_axi_bvalid;
	assign lane0     = w_strb[0];
	assign wr_enable = do_write && lane0
		&& aw_addr == revflg_pkg::REVFLG_OFS_ENABLE;
	assign wr_clear  = do_write && lane0
		&& aw_addr == revflg_pkg::REVFLG_OFS_CLEAR;

	// ------------------------------------------------------------------
	// write response
	// ------------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= revflg_pkg::REVFLG_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			// flag register is read-only, writes to it are ignored
			if (aw_addr == revflg_pkg::REVFLG_OFS_ENABLE
					|| aw_addr == revflg_pkg::REVFLG_OFS_FLAGS
					|| aw_addr == revflg_pkg::REVFLG_OFS_CLEAR)
				s_axi_bresp <= revflg_pkg::REVFLG_RESP_OKAY;
			else
				s_axi_bresp <= revflg_pkg::REVFLG_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// enable register
	// ------------------------------------------------------------------
	// reserved bit 5 is not stored, so a careless write cannot enable it
	always_comb begin
		next_enable = enable;
		if (wr_enable) begin
			next_enable = w_data[6:0] & revflg_pkg::REVFLG_IMPL_MASK;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			enable <= revflg_pkg::REVFLG_RST_ENABLE;
		end else begin
			enable <= next_enable;
		end
	end

	// ------------------------------------------------------------------
	// sticky flags, one per source
	// ------------------------------------------------------------------
	// a zero in a written clear bit clears, a one keeps the flag
	assign clear_vec = wr_clear ? (~w_data[6:0]
		& revflg_pkg::REVFLG_IMPL_MASK) : 7'h00;

	genvar gi;
	generate
		for (gi = 0; gi < revflg_pkg::REVFLG_NUM_SRC; gi++) begin : g_flag
			// set wins over clear so a coincident event is never lost
			assign next_flags[gi] = event_vec[gi]
				|| (flags[gi] && !clear_vec[gi]);
		end
	endgenerate

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flags <= revflg_pkg::REVFLG_RST_FLAGS;
		end else begin
			flags <= next_flags & revflg_pkg::REVFLG_IMPL_MASK;
		end
	end

	// ------------------------------------------------------------------
	// interrupt request
	// ------------------------------------------------------------------
	// taken from next values so irq tracks both registers without lag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(next_flags & next_enable
				& revflg_pkg::REVFLG_IMPL_MASK);
		end
	end

	// ------------------------------------------------------------------
	// read channel
	// ------------------------------------------------------------------
	assign rd_take = s_axi_arvalid && s_axi_arready;

	always_comb begin
		rd_word.data = revflg_pkg::REVFLG_ZERO_WORD;
		rd_word.resp = revflg_pkg::REVFLG_RESP_OKAY;
		case (s_axi_araddr)
			revflg_pkg::REVFLG_OFS_ENABLE: begin
				rd_word.data[6:0] = enable;
			end
			revflg_pkg::REVFLG_OFS_FLAGS: begin
				rd_word.data[6:0] = flags;
			end
			revflg_pkg::REVFLG_OFS_CLEAR: begin
				rd_word.data = revflg_pkg::REVFLG_RST_CLEAR;
			end
			default: begin
				rd_word.resp = revflg_pkg::REVFLG_RESP_SLVERR;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !rd_take;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= revflg_pkg::REVFLG_ZERO_WORD;
			s_axi_rresp  <= revflg_pkg::REVFLG_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word.data;
			s_axi_rresp  <= rd_word.resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : revflg_unit

`default_nettype wire

/* tb/revflg_props.sv */
// checker for the event flag unit: bus answers, read values, irq causes
// assumes it is bound to revflg_unit and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module revflg_props (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire revflg_pkg::revflg_events_t events,
	input wire logic                       s_axi_awvalid,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wvalid,
	input wire logic                       s_axi_wready,
	input wire logic [1:0]                 s_axi_bresp,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic [7:0]                 s_axi_araddr,
	input wire logic                       s_axi_arvalid,
	input wire logic                       s_axi_arready,
	input wire logic [31:0]                s_axi_rdata,
	input wire logic [1:0]                 s_axi_rresp,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	input wire logic                       irq
);
	// ------------------------------------------------------------------
	// helpers and sequences
	// ------------------------------------------------------------------
	wire ev_any = |events;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence b_answer;
		##2 s_axi_bvalid;
	endsequence
	// irq moves on the edge where bvalid rises after a write; one edge later is also allowed
	sequence wr_done;
		$rose(s_axi_bvalid) || $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
	endsequence
	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	AST_WR_ANSWER: assert property (wr_take |-> b_answer)
		else $error("write answer missing");
	AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp moved");
	AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
	AST_RD_CLEAR: assert property (rd_take && s_axi_araddr == 8'h38
		|=> s_axi_rdata == 32'h0000007F && s_axi_rresp == 2'h0)
		else $error("clear register readback wrong");
	AST_RD_RSVD: assert property (rd_take && s_axi_araddr[7:3] == 5'h06
		|=> s_axi_rdata[31:7] == 25'h0 && !s_axi_rdata[5])
		else $error("reserved bits read nonzero");
	AST_RD_UNMAP: assert property (rd_take
		&& !(s_axi_araddr inside {8'h30, 8'h34, 8'h38})
		|=> s_axi_rdata == 32'h0 && s_axi_rresp == 2'h2)
		else $error("unmapped read not refused");
	AST_IRQ_FALL: assert property ($fell(irq) |-> wr_done)
		else $error("irq dropped without a write");
	AST_IRQ_RISE: assert property ($rose(irq) |-> $past(ev_any) or wr_done)
		else $error("irq rose without cause");
endmodule : revflg_props
bind revflg_unit revflg_props u_props (.aclk, .aresetn, .events,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .irq);
`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the event flag unit with a flag/enable model
// assumes revflg_unit and its package are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic                       aclk    = 1'h0;
	logic                       aresetn = 1'h0;
	revflg_pkg::revflg_events_t events  = '0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata  = 32'h0;
	logic [31:0] lfsr   = 32'hC11F7174;
	logic [3:0]  wstrb  = 4'hF;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic        arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          error_cnt = 0, checked = 0, cyc = 0, en = 0, fl = 0;
	always #10 aclk = ~aclk;
	revflg_unit u_revflg_unit (.aclk(aclk), .aresetn(aresetn),
		.events(events), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq(irq));
	// ------------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------------
	function automatic logic [31:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr;
	endfunction : rnd
	task automatic close_out();
		if (error_cnt == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		chk(bresp, er);
		bready <= 1'h0;
		@(posedge aclk);
		if (a == 8'h30 && wstrb[0]) en = d & 32'h5F;
		if (a == 8'h38 && wstrb[0]) fl = fl & (d | 32'hFFFFFFA0);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		chk(rdata, e);
		chk(rresp, er);
		rready <= 1'h0;
		@(posedge aclk);
	endtask : rd
	// packed struct is msb first, so the first alarm lands on flag bit 0
	task automatic ev(input logic [5:0] e);
		events <= e;
		@(posedge aclk);
		events <= '0;
		@(posedge aclk);
		fl = fl | {e[0], 1'h0, e[1], e[2], e[3], e[4], e[5]};
		chk(irq, |(fl & en));
	endtask : ev
	// ------------------------------------------------------------------
	// sequence
	// ------------------------------------------------------------------
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			close_out();
		end
	end
	initial begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rd(8'h30, 32'h0, 2'h0);
		rd(8'h34, 32'h0, 2'h0);
		rd(8'h38, 32'h7F, 2'h0);
		rd(8'h3C, 32'h0, 2'h2);
		wr(8'h40, 32'hFFFFFFFF, 2'h2);
		for (int i = 0; i < 8; i++) begin
			wr(8'h30, rnd() & 32'h5F, 2'h0);
			rd(8'h30, en, 2'h0);
		end
		wstrb <= 4'hE;
		wr(8'h30, 32'h0, 2'h0);
		wstrb <= 4'hF;
		rd(8'h30, en, 2'h0);
		wr(8'h30, 32'h0A, 2'h0);
		for (int k = 5; k >= 0; k--) begin
			ev(6'h01 << k);
			rd(8'h34, fl, 2'h0);
		end
		wr(8'h34, 32'h0, 2'h0);
		rd(8'h34, fl, 2'h0);
		for (int i = 0; i < 6; i++) begin
			wr(8'h38, (rnd() & 32'h5F) | 32'h20, 2'h0);
			rd(8'h34, fl, 2'h0);
			chk(irq, |(fl & en));
			ev(rnd());
			wr(8'h30, rnd() & 32'h5F, 2'h0);
			chk(irq, |(fl & en));
		end
		events <= 6'h20;
		wr(8'h38, 32'h20, 2'h0);
		events <= '0;
		fl = 1;
		rd(8'h34, fl, 2'h0);
		wr(8'h38, 32'h20, 2'h0);
		rd(8'h34, 32'h0, 2'h0);
		chk(irq, 1'h0);
		close_out();
	end
endmodule : tb
`default_nettype wire
